// ---- include/nir_defines.svh ----
`ifndef NIR_DEFINES_SVH
`define NIR_DEFINES_SVH
// Summary of operation
// R1: ID read is 90h, address 00h, five bytes
// R2: address 20h returns four ONFI signature bytes
// R3: descriptor byte two fields decoded
// R4: descriptor byte three fields decoded
// R5: descriptor byte four fields decoded
// R6: status appears after 70h on later falling strobe
// R7: status mode holds until next command
// R8: status bits pass, cache fail, protect
// R9: bit five tracks internal engine
// R10: bit six tracks ready pin
// R11: 78h plus row address gives plane status
// R12: enhanced status bits shared or per plane
// R13: no 78h during reset or OTP
// R14: 7Ah plus three block address cycles
// R15: protection output bit meanings
// R16: solid lock freezes other protection
// R17: x8 block address cycle layout
// R18: x16 block address cycle layout
// R19: status only with own CE and RE
// R20: reset clears status to E0h
// R21: write 00h to leave status mode
// R22: ready pin low until data available
// R23: x16 upper lines low in byte readouts
// R24: lines float when strobes released

// flash commands, id addresses, onfi signature and reset status
`define NIR_CMD_READ        8'h00
`define NIR_CMD_ID          8'h90
`define NIR_CMD_STATUS      8'h70
`define NIR_CMD_ESTATUS     8'h78
`define NIR_CMD_PROT        8'h7a
`define NIR_CMD_RESET       8'hff
`define NIR_ID_ADDR_STD     8'h00
`define NIR_ID_ADDR_ONFI    8'h20
`define NIR_ONFI_SIG        32'h49464e4f
`define NIR_STATUS_RESET    8'he0
// apb register offsets
`define NIR_OFF_CTRL        12'h000
`define NIR_OFF_ADDR        12'h004
`define NIR_OFF_STAT        12'h008
`define NIR_OFF_DATA0       12'h00c
`define NIR_OFF_DATA1       12'h010
// ctrl fields
`define NIR_CTRL_GO         0
`define NIR_CTRL_OP_LSB     1
`define NIR_CTRL_X16        4
// stat fields
`define NIR_ST_BUSY         0
`define NIR_ST_DONE         1
`define NIR_ST_RDY          2
`define NIR_ST_ONFI         3
`define NIR_ST_LOCKED       4
`define NIR_ST_BLK_UNP      5
`define NIR_ST_REFUSED      6
// timing: strobe phase length in core cycles, 20 ns
`define NIR_T_STROBE_NS     20
`define NIR_CLK_NS          10
`define NIR_STROBE_CYC      ((`NIR_T_STROBE_NS + `NIR_CLK_NS - 1) / `NIR_CLK_NS)
`endif

// ---- include/nir_pkg.sv ----
package nir_pkg;
	typedef enum logic [2:0] {
		NIR_OP_ID     = 3'b000,
		NIR_OP_ONFI   = 3'b001,
		NIR_OP_STATUS = 3'b010,
		NIR_OP_ESTAT  = 3'b011,
		NIR_OP_PROT   = 3'b100,
		NIR_OP_RESET  = 3'b101,
		NIR_OP_READ   = 3'b110
	} nir_op_t;
	typedef enum logic [2:0] {
		NIR_S_IDLE  = 3'b000,
		NIR_S_CMD   = 3'b001,
		NIR_S_ADDR  = 3'b010,
		NIR_S_WAIT  = 3'b011,
		NIR_S_READ  = 3'b100,
		NIR_S_GAP   = 3'b101
	} nir_state_t;
endpackage

// ---- logic/nir_host.sv ----
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "nir_defines.svh"
module nir_host #(
	parameter int STROBE_CYC = `NIR_STROBE_CYC
) (
	input  wire logic        core_clk,      // 100 MHz
	input  wire logic        rst_n,         // async, active low
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb enable
	input  wire logic        pwrite,        // apb direction
	input  wire logic [11:0] paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error
	output logic             ce_n,          // chip enable
	output logic             cle,           // command latch
	output logic             ale,           // address latch
	output logic             we_n,          // write strobe
	output logic             read_strobe_n, // read strobe
	output logic      [15:0] io_out,        // io drive value
	output logic      [15:0] io_oe_n,       // io enable, low drives
	input  wire logic [15:0] io_in,         // io sampled value
	input  wire logic        rb_n           // ready/busy pin
);
	import nir_pkg::*;

	// elaboration check, phase timer is eight bits
	if (STROBE_CYC < 1 || STROBE_CYC > 255) begin : g_bad_strobe
		$error("STROBE_CYC out of range");
	end

	nir_state_t  state_reg, state_next;
	nir_op_t     op_reg, op_next;
	logic [7:0]  tmr_reg, tmr_next;
	logic [2:0]  cnt_reg, cnt_next;
	logic [2:0]  nadr_reg, nadr_next;
	logic [2:0]  nrd_reg, nrd_next;
	logic        ph_reg, ph_next;
	logic        x16_reg, x16_next;
	logic [23:0] addr_reg, addr_next;
	logic [63:0] data_reg, data_next;
	logic        done_reg, done_next;
	logic        refused_reg, refused_next;
	logic [7:0]  cmd_byte;
	logic [7:0]  adr_byte;
	logic        wr_acc, rd_acc;

	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// command byte of each operation
	function automatic logic [7:0] op_cmd(input nir_op_t op);
		case (op)
			NIR_OP_ID:     op_cmd = `NIR_CMD_ID;
			NIR_OP_ONFI:   op_cmd = `NIR_CMD_ID;
			NIR_OP_STATUS: op_cmd = `NIR_CMD_STATUS;
			NIR_OP_ESTAT:  op_cmd = `NIR_CMD_ESTATUS;
			NIR_OP_PROT:   op_cmd = `NIR_CMD_PROT;
			NIR_OP_RESET:  op_cmd = `NIR_CMD_RESET;
			// R21 read op sends 00h
			default:       op_cmd = `NIR_CMD_READ;
		endcase
	endfunction

	// block address byte k, x8 layout also used for x16; addr holds block bits
	function automatic logic [7:0] blk_byte(input logic [23:0] a, input logic [2:0] k,
		input logic w16);
		logic [10:0] b;
		b = a[10:0];
		case (k)
			3'd0:    blk_byte = {b[1:0], 6'h00};
			3'd1:    blk_byte = b[9:2];
			3'd2:    blk_byte = {7'h00, b[10]};
			default: blk_byte = 8'h00;
		endcase
		if (w16) begin
			blk_byte = blk_byte;
		end
	endfunction

	assign cmd_byte = op_cmd(op_reg);

	// address byte of the cycle the pins enter next, so io settles with the low phase
	always_comb begin
		adr_byte = 8'h00;
		case (op_reg)
			NIR_OP_ID:    adr_byte = `NIR_ID_ADDR_STD;
			NIR_OP_ONFI:  adr_byte = `NIR_ID_ADDR_ONFI;
			// R17 R18 block cycles
			NIR_OP_PROT,
			NIR_OP_ESTAT: adr_byte = blk_byte(addr_reg, cnt_next, x16_reg);
			default:      adr_byte = 8'h00;
		endcase
	end

	// sequencer next state
	always_comb begin
		state_next   = state_reg;
		op_next      = op_reg;
		tmr_next     = tmr_reg;
		cnt_next     = cnt_reg;
		nadr_next    = nadr_reg;
		nrd_next     = nrd_reg;
		ph_next      = ph_reg;
		x16_next     = x16_reg;
		addr_next    = addr_reg;
		data_next    = data_reg;
		done_next    = done_reg;
		refused_next = refused_reg;
		if (wr_acc && paddr == `NIR_OFF_ADDR) begin
			addr_next = pwdata[23:0];
		end
		if (wr_acc && paddr == `NIR_OFF_CTRL && pwdata[`NIR_CTRL_GO]) begin
			if (state_reg != NIR_S_IDLE) begin
				refused_next = 1'b1;
			end else if (nir_op_t'(pwdata[`NIR_CTRL_OP_LSB +: 3]) == NIR_OP_ESTAT
				&& !rb_n) begin
				// R13 no plane status while busy
				refused_next = 1'b1;
			end else begin
				op_next      = nir_op_t'(pwdata[`NIR_CTRL_OP_LSB +: 3]);
				x16_next     = pwdata[`NIR_CTRL_X16];
				done_next    = 1'b0;
				refused_next = 1'b0;
				state_next   = NIR_S_CMD;
				tmr_next     = 8'(STROBE_CYC);
				ph_next      = 1'b0;
				cnt_next     = 3'd0;
				data_next    = 64'h0;
				// R1 R14 cycle counts
				case (nir_op_t'(pwdata[`NIR_CTRL_OP_LSB +: 3]))
					NIR_OP_ID:     begin nadr_next = 3'd1; nrd_next = 3'd5; end
					NIR_OP_ONFI:   begin nadr_next = 3'd1; nrd_next = 3'd4; end
					NIR_OP_STATUS: begin nadr_next = 3'd0; nrd_next = 3'd1; end
					NIR_OP_ESTAT:  begin nadr_next = 3'd3; nrd_next = 3'd1; end
					NIR_OP_PROT:   begin nadr_next = 3'd3; nrd_next = 3'd1; end
					default:       begin nadr_next = 3'd0; nrd_next = 3'd0; end
				endcase
			end
		end
		// advance the transfer; a refused request does not stall it
		if (state_reg != NIR_S_IDLE) begin
			if (tmr_reg > 8'd1) begin
				tmr_next = tmr_reg - 8'd1;
			end else begin
				tmr_next = 8'(STROBE_CYC);
				ph_next  = !ph_reg;
				case (state_reg)
					NIR_S_CMD: if (ph_reg) begin
						cnt_next   = 3'd0;
						ph_next    = 1'b0;
						state_next = (nadr_reg != 3'd0) ? NIR_S_ADDR : NIR_S_WAIT;
					end
					NIR_S_ADDR: if (ph_reg) begin
						ph_next = 1'b0;
						if (cnt_reg + 3'd1 == nadr_reg) begin
							cnt_next   = 3'd0;
							state_next = NIR_S_WAIT;
						end else begin
							cnt_next = cnt_reg + 3'd1;
						end
					end
					NIR_S_WAIT: begin
						ph_next = 1'b0;
						// R22 wait for ready pin
						if (rb_n) begin
							state_next = (nrd_reg != 3'd0) ? NIR_S_READ : NIR_S_GAP;
						end
					end
					NIR_S_READ: if (ph_reg) begin
						ph_next = 1'b0;
						if (cnt_reg + 3'd1 == nrd_reg) begin
							state_next = NIR_S_GAP;
						end else begin
							cnt_next = cnt_reg + 3'd1;
						end
					end else begin
						// R23 low byte sampled, R3 R4 R5 R8 bytes kept raw
						data_next = data_reg | (64'(io_in[7:0]) << {cnt_reg, 3'b000});
					end
					NIR_S_GAP: begin
						ph_next    = 1'b0;
						state_next = NIR_S_IDLE;
						done_next  = 1'b1;
					end
					default: state_next = NIR_S_IDLE;
				endcase
			end
		end
	end

	// sequencer registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= NIR_S_IDLE;
			op_reg      <= NIR_OP_ID;
			tmr_reg     <= 8'h01;
			cnt_reg     <= 3'd0;
			nadr_reg    <= 3'd0;
			nrd_reg     <= 3'd0;
			ph_reg      <= 1'b0;
			x16_reg     <= 1'b0;
			addr_reg    <= 24'h0;
			data_reg    <= 64'h0;
			done_reg    <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			op_reg      <= op_next;
			tmr_reg     <= tmr_next;
			cnt_reg     <= cnt_next;
			nadr_reg    <= nadr_next;
			nrd_reg     <= nrd_next;
			ph_reg      <= ph_next;
			x16_reg     <= x16_next;
			addr_reg    <= addr_next;
			data_reg    <= data_next;
			done_reg    <= done_next;
			refused_reg <= refused_next;
		end
	end

	// pin drive, registered off the next state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ce_n          <= 1'b1;
			cle           <= 1'b0;
			ale           <= 1'b0;
			we_n          <= 1'b1;
			read_strobe_n <= 1'b1;
			io_out        <= 16'h0000;
			io_oe_n       <= 16'hffff;
		end else begin
			// R19 ce held low only for own transfer
			ce_n          <= (state_next == NIR_S_IDLE);
			cle           <= (state_next == NIR_S_CMD);
			ale           <= (state_next == NIR_S_ADDR);
			we_n          <= !((state_next == NIR_S_CMD || state_next == NIR_S_ADDR)
				&& !ph_next);
			// R6 read strobe falls after ce
			read_strobe_n <= !(state_next == NIR_S_READ && !ph_next);
			io_out        <= {8'h00, (state_next == NIR_S_CMD) ? op_cmd(op_next) : adr_byte};
			// R24 released while reading
			io_oe_n       <= (state_next == NIR_S_CMD || state_next == NIR_S_ADDR) ?
				16'h0000 : 16'hffff;
		end
	end

	// apb read mux
	always_comb begin
		prdata = 32'h0;
		case (paddr)
			`NIR_OFF_CTRL:  prdata = {27'h0, x16_reg, op_reg, 1'b0};
			`NIR_OFF_ADDR:  prdata = {8'h00, addr_reg};
			`NIR_OFF_STAT:  begin
				prdata[`NIR_ST_BUSY]    = (state_reg != NIR_S_IDLE);
				prdata[`NIR_ST_DONE]    = done_reg;
				prdata[`NIR_ST_RDY]     = rb_n;
				// R2 signature check
				prdata[`NIR_ST_ONFI]    = (data_reg[31:0] == `NIR_ONFI_SIG);
				// R15 R16 protection decode
				prdata[`NIR_ST_LOCKED]  = (data_reg[1:0] == 2'b01);
				prdata[`NIR_ST_BLK_UNP] = data_reg[2];
				prdata[`NIR_ST_REFUSED] = refused_reg;
			end
			`NIR_OFF_DATA0: prdata = data_reg[31:0];
			`NIR_OFF_DATA1: prdata = data_reg[63:32];
			default:        prdata = 32'h0;
		endcase
		if (!rd_acc) begin
			prdata = 32'h0;
		end
	end

	// status and id bytes kept raw, software decodes the fields

	// R19 reads only with ce low
	AST_RE_NEEDS_CE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!read_strobe_n |-> !ce_n) else $error("read strobe without ce"); // R19
	// R24 no drive while reading
	AST_NO_DRIVE_RD: assert property (@(posedge core_clk) disable iff (!rst_n)
		!read_strobe_n |-> io_oe_n == 16'hffff) else $error("drive during read"); // R24
	// R1 id command byte
	AST_ID_CMD: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cle && !io_oe_n[0] && op_reg == NIR_OP_ID) |-> io_out[7:0] == 8'h90)
		else $error("bad id command"); // R1
	// R2 onfi address
	AST_ONFI_ADR: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ale && op_reg == NIR_OP_ONFI) |-> io_out[7:0] == 8'h20)
		else $error("bad onfi address"); // R2
	// R14 prot command
	AST_PROT_CMD: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cle && op_reg == NIR_OP_PROT) |-> io_out[7:0] == 8'h7a)
		else $error("bad prot command"); // R14
	// R17 x8 cycle three upper lines low
	AST_BLK3: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ale && cnt_reg == 3'd2) |-> io_out[7:1] == 7'h00) else $error("blk3 bits"); // R17
	// R18 upper lines low
	AST_UPPER_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
		ale |-> io_out[15:8] == 8'h00) else $error("upper lines driven"); // R18
	// R13 plane status refused when busy
	AST_ESTAT_BUSY: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_acc && paddr == `NIR_OFF_CTRL && pwdata[0] && pwdata[3:1] == 3'b011 && !rb_n
		&& state_reg == NIR_S_IDLE) |=> refused_reg && state_reg == NIR_S_IDLE)
		else $error("estat while busy"); // R13
	// R22 no read before ready
	AST_WAIT_RDY: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_reg == NIR_S_WAIT && !rb_n) |=> state_reg != NIR_S_READ)
		else $error("read while busy"); // R22
endmodule

// ---- test/nir_flash_model.sv ----
`timescale 1ns/1ps
// behavioural flash die for id, status and protection reads
module nir_flash_model #(
	parameter logic [7:0]  MFR_CODE = 8'h5a,  // arbitrary value
	parameter logic [7:0]  DEV_CODE = 8'h3c,  // arbitrary value
	parameter logic [10:0] OPEN_BLK = 11'h2a5 // the unprotected block
) (
	input  wire logic        ce_n,          // chip enable
	input  wire logic        cle,           // command latch
	input  wire logic        ale,           // address latch
	input  wire logic        we_n,          // write strobe
	input  wire logic        read_strobe_n, // read strobe
	input  wire logic [15:0] io_out,        // host drive value
	input  wire logic [15:0] io_oe_n,       // host enable, low drives
	input  wire logic [3:0]  fail_bits,     // plane1, plane0 fail pairs
	input  wire logic        solid,         // solid lock state
	input  wire logic [15:0] busy_ns,       // reset busy time
	output logic      [15:0] io_in,         // data to host
	output logic             rb_n,          // ready/busy
	output logic             bad            // host misbehaved
);
	logic [7:0]  cmd, q;
	logic [7:0]  ad [0:2];
	logic [3:0]  fl;
	logic [10:0] blk;
	int          na, nr;
	initial begin
		{cmd, na, nr, bad, fl} = 0;
		rb_n = 1'b1;
		io_in = 16'h5a5a;
	end
	// fail results follow stimulus until a reset
	always @(fail_bits) fl = fail_bits;
	always @(posedge we_n) begin
		if (!ce_n && io_out[15:8] !== 8'h00) bad = 1'b1;
		if (!ce_n && io_oe_n !== 16'h0000) bad = 1'b1;
		if (!ce_n && cle) begin
			if (io_out[7:0] == 8'h78 && !rb_n) bad = 1'b1;
			cmd = io_out[7:0];
			na = 0;
			nr = 0;
			if (cmd == 8'hff) begin
				rb_n = 1'b0;
				#(busy_ns);
				fl = 4'h0;
				rb_n = 1'b1;
			end
		end else if (!ce_n && ale) begin
			if (na < 3) ad[na] = io_out[7:0];
			na++;
		end
	end
	// drive on the later falling strobe only
	always @(negedge ce_n or negedge read_strobe_n) begin
		if (!ce_n && !read_strobe_n) begin
			// host must have released the lines
			if (io_oe_n !== 16'hffff) bad = 1'b1;
			blk = {ad[2][0], ad[1], ad[0][7:6]};
			if ((cmd == 8'h78 || cmd == 8'h7a) && (na != 3 || ad[0][5:0] != 0
					|| ad[2][7:1] != 0)) bad = 1'b1;
			case (cmd)
				8'h90: q = ad[0] == 8'h20 ? 8'(32'h49464e4f >> 8 * nr)
						: 8'({8'h56, 8'h15, 8'h90, DEV_CODE, MFR_CODE} >> 8 * nr);
				8'h70: q = {1'b1, rb_n, rb_n, 3'b0, fl[3:2] | fl[1:0]};
				// shared bits 6, 5, plane bits from row
				8'h78: q = {1'b1, rb_n, rb_n, 3'b0, blk[0] ? fl[3:2] : fl[1:0]};
				// protection word, lock fixed per run
				8'h7a: q = {5'b0, blk == OPEN_BLK, ~solid, solid};
				default: q = 8'h00;
			endcase
			io_in = {8'h00, q};
			nr++;
		end
	end
	// each rising ce or read strobe inverts the lines
	always @(posedge ce_n or posedge read_strobe_n) io_in = ~io_in;
endmodule

// ---- test/nir_host_tb.sv ----
`timescale 1ns/1ps
`include "nir_defines.svh"
module nir_host_tb;
	import nir_pkg::*;
	logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        ce_n, cle, ale, we_n, read_strobe_n, rb_n, bad, solid;
	logic        flash_rb_n, peer_rb_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, last;
	logic [15:0] io_out, io_oe_n, io_in, busy_ns;
	logic [3:0]  fail_bits, fb;
	logic [10:0] b;
	logic [31:0] exp_q[$], msk_q[$];
	int          n_fail, comparisons;
	nir_host u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
		.rb_n(rb_n));
	nir_flash_model u_flash (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe_n(io_oe_n),
		.fail_bits(fail_bits), .solid(solid), .busy_ns(busy_ns), .io_in(io_in),
		.rb_n(flash_rb_n), .bad(bad));
	// ready/busy line wired with a second die
	assign rb_n = flash_rb_n & peer_rb_n;
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			n_fail++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// apb transfer held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		last = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] want, input logic [31:0] m);
		exp_q.push_back(want);
		msk_q.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic go(input nir_op_t o);
		apb(1'b1, `NIR_OFF_CTRL, {28'h0, o, 1'b1});
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		last = 0;
		while (last[1] !== 1'b1 && n < 3000) begin
			rd(`NIR_OFF_STAT, 0, 0);
			n++;
		end
		if (n >= 3000) n_fail++;
	endtask
	task automatic run(input nir_op_t o, input logic [10:0] blk);
		apb(1'b1, `NIR_OFF_ADDR, {21'h0, blk});
		go(o);
		wait_done();
	endtask
	// compare each read with a nonzero mask against the oldest note
	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			check({31'h0, pslverr}, 32'h0);
			if (msk_q[0] != 0) check(prdata & msk_q[0], exp_q[0] & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, fail_bits, solid} = 0;
		{n_fail, comparisons} = 0;
		busy_ns = 16'd200;
		peer_rb_n = 1'b1;
		rst_n = 1'b0;
		void'($urandom(35));
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		run(NIR_OP_ID, 11'h0);
		rd(`NIR_OFF_DATA0, {16'h1590, u_flash.DEV_CODE, u_flash.MFR_CODE}, '1);
		rd(`NIR_OFF_DATA1, 32'h56, 32'hff);
		// same id read in x16 mode, bytes still on the low lines
		apb(1'b1, `NIR_OFF_CTRL, 32'h11);
		wait_done();
		rd(`NIR_OFF_CTRL, 32'h10, '1);
		rd(`NIR_OFF_DATA0, {16'h1590, u_flash.DEV_CODE, u_flash.MFR_CODE}, '1);
		$display("id test done");
		run(NIR_OP_ONFI, 11'h0);
		rd(`NIR_OFF_DATA0, 32'h49464e4f, '1);
		rd(`NIR_OFF_STAT, 32'hc, 32'hc);
		$display("signature test done");
		repeat (3) begin
			fb = 4'($urandom);
			fail_bits <= fb;
			run(NIR_OP_STATUS, 11'h0);
			rd(`NIR_OFF_DATA0, {24'h0, 6'h38, fb[3:2] | fb[1:0]}, 32'hff);
			for (int p = 0; p < 2; p++) begin
				b = {10'($urandom), 1'(p)};
				run(NIR_OP_ESTAT, b);
				rd(`NIR_OFF_DATA0, {24'h0, 6'h38, p ? fb[3:2] : fb[1:0]}, 32'hff);
			end
		end
		run(NIR_OP_READ, 11'h0);
		check({24'h0, u_flash.cmd}, 32'h0);
		$display("status test done");
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 2; k++) begin
				b = k ? 11'($urandom) : u_flash.OPEN_BLK;
				solid <= 1'(s);
				run(NIR_OP_PROT, b);
				rd(`NIR_OFF_DATA0, {29'h0, b == u_flash.OPEN_BLK, ~1'(s), 1'(s)}, 32'h7);
				rd(`NIR_OFF_STAT, {26'h0, b == u_flash.OPEN_BLK, 1'(s), 4'h0}, 32'h30);
				rd(`NIR_OFF_ADDR, {21'h0, b}, '1);
				rd(`NIR_OFF_CTRL, 32'h8, '1);
			end
		end
		$display("protection test done");
		// other die busy on the shared line while this one idles
		peer_rb_n <= 1'b0;
		go(NIR_OP_ESTAT);
		rd(`NIR_OFF_STAT, 32'h42, 32'h47);
		peer_rb_n <= 1'b1;
		fail_bits <= 4'h5;
		busy_ns <= 16'(400 + $urandom_range(1600));
		go(NIR_OP_RESET);
		go(NIR_OP_ESTAT);
		rd(`NIR_OFF_STAT, 32'h41, 32'h41);
		wait_done();
		run(NIR_OP_STATUS, 11'h0);
		rd(`NIR_OFF_DATA0, 32'he0, 32'hff);
		check({31'h0, bad}, 32'h0);
		$display("reset test done");
		summarize();
	end
	initial begin
		#1000000;
		n_fail++;
		summarize();
	end
endmodule
